// File: logic/dbgp_pkg.sv
// Shared constants and types of the debug probe and boot strap block.
// Assumes a single 125 MHz clock domain; used by dbgp_top and the verification files.
package dbgp_pkg;
   // Register offsets on the plain register port
   localparam logic [7:0] DBGP_REG_DIG_PROBE = 8'h00;
   localparam logic [7:0] DBGP_REG_ANA_PROBE = 8'h04;
   localparam logic [7:0] DBGP_REG_STATUS = 8'h08;
   localparam logic [7:0] DBGP_REG_VERSION = 8'h0C;

   // Field positions inside the digital probe register
   localparam int DBGP_GROUP_LSB = 0;
   localparam int DBGP_POS_LSB = 8;
   // Field positions inside the analog probe register
   localparam int DBGP_ANA1_LSB = 0;
   localparam int DBGP_ANA2_LSB = 8;
   localparam int DBGP_ANA1_EN_BIT = 16;
   localparam int DBGP_ANA2_EN_BIT = 17;

   // Probe group codes
   localparam logic [7:0] DBGP_GRP_CLOCK = 8'h01;
   localparam logic [7:0] DBGP_GRP_TX_ENC = 8'h1B;
   localparam logic [7:0] DBGP_GRP_TIMER = 8'h1D;
   localparam logic [7:0] DBGP_GRP_CARD = 8'h30;
   localparam logic [7:0] DBGP_GRP_TRANSCEIVE = 8'h58;
   localparam logic [7:0] DBGP_GRP_RX_DATA = 8'h70;
   localparam logic [7:0] DBGP_GRP_RX_ERR = 8'h73;
   localparam int DBGP_NUM_GROUPS = 7;
   localparam int DBGP_SIGS_PER_GROUP = 9;

   // Output pin codes held in the high nibble of the position parameter
   localparam logic [3:0] DBGP_PIN_IRQ = 4'h0;
   localparam logic [3:0] DBGP_PIN_GENERAL_OUTPUT_ONE = 4'h1;
   localparam logic [3:0] DBGP_PIN_AUX_OUT_TWO = 4'h2;
   localparam logic [3:0] DBGP_PIN_AUX_OUT_ONE = 4'h3;

   // Reset values and the hash step constant
   localparam logic [15:0] DBGP_DIG_PROBE_RST = 16'hF000;
   localparam logic [17:0] DBGP_ANA_PROBE_RST = 18'h00000;
   localparam logic [31:0] DBGP_HASH_SEED = 32'h6A09E667;
   localparam logic [31:0] DBGP_HASH_ADD = 32'h9E3779B9;

   // Settle count at which the strap is sampled after reset release; covers the two synchroniser stages
   localparam logic [1:0] DBGP_STRAP_SETTLE = 2'h3;

   typedef enum logic [1:0] {
      DBGP_OP_AUTH,
      DBGP_OP_HEADER,
      DBGP_OP_DATA,
      DBGP_OP_FINISH
   } dbgp_op_type;

   typedef enum logic [2:0] {
      DBGP_RSP_OK,
      DBGP_RSP_LOCKED,
      DBGP_RSP_AUTH_FAIL,
      DBGP_RSP_OLD_MAJOR,
      DBGP_RSP_BAD_HASH,
      DBGP_RSP_SEQUENCE
   } dbgp_rsp_code_type;

   typedef struct packed {
      dbgp_op_type opcode;
      logic [31:0] arg;
   } dbgp_cmd_type;

   typedef struct packed {
      logic irq;
      logic general_output_one;
      logic aux_out_one;
      logic aux_out_two;
   } dbgp_pins_type;
endpackage : dbgp_pkg

// File: logic/dbgp_sync2.sv
// Two-stage synchroniser for a level that comes from a device pin.
// Assumes the level changes slowly compared with the clock.
`timescale 1ns/1ps
module dbgp_sync2 (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic sync_o
);
   logic stage1;

   // The first stage feeds only the second one
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         stage1 <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule : dbgp_sync2

// File: logic/dbgp_top.sv
// Debug probe routing, analog probe selection, boot strap and download gate.
// Assumes the core gives probe groups, analog sources and commands on mclk_i.
//
// What this block does
// R1: Bits 7:4 of the position parameter pick the digital probe pin 0..3.
// R2: Low nibble of the position parameter picks the signal within the group.
// R3: The first probe parameter is the group code, such as 01, 1B or 73.
// R4: At most two analog probes, one on each auxiliary pin.
// R5: Two converters carry selected internal words, chosen by two parameters.
// R6: Auxiliary two is an input from power-up until boot-complete idle interrupt.
// R7: Strap high during start-up enters download mode, else normal boot.
// R8: After boot completes the strap pin becomes a debug output.
// R9: Host holds reset, raises strap, then releases reset to ask for download.
// R10: Host lowers strap then resets the device to leave download mode.
// R11: In download mode commands go to the download engine, not the normal set.
// R12: Download is locked until authentication; image checked with a hash.
// R13: Image carries major and minor version; lower major is rejected.
// R14: A reserved pin code leaves all four pins normal, no probe routed.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module dbgp_top
   import dbgp_pkg::*;
#(
   parameter int ANA_SRC = 16,
   parameter int DAC_W = 8,
   parameter logic [31:0] AUTH_KEY = 32'h5A5A0001, // Arbitrary value
   parameter logic [7:0] INIT_MAJOR = 8'h01,
   parameter logic [7:0] INIT_MINOR = 8'h00
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic [DBGP_NUM_GROUPS*DBGP_SIGS_PER_GROUP-1:0] probe_groups_i,
   input wire logic [ANA_SRC*DAC_W-1:0] ana_src_i,
   input wire dbgp_pins_type pin_func_i,
   input wire logic boot_idle_irq_i,
   input wire logic aux_out_two_in_i,
   output dbgp_pins_type pin_out_o,
   output logic aux_out_two_oe_o,
   output logic [DAC_W-1:0] aux_out_one_dac_o,
   output logic [DAC_W-1:0] aux_out_two_dac_o,
   output logic aux_out_one_dac_en_o,
   output logic aux_out_two_dac_en_o,
   input wire logic cmd_valid_i,
   input wire dbgp_cmd_type cmd_i,
   output logic normal_cmd_valid_o,
   output dbgp_cmd_type normal_cmd_o,
   output logic dl_rsp_valid_o,
   output dbgp_rsp_code_type dl_rsp_o
);
   typedef enum {ST_SETTLE, ST_STARTUP, ST_RUN} dbgp_boot_type;
   typedef enum {DL_LOCKED, DL_OPEN, DL_IMAGE} dbgp_dl_type;

   localparam int SEL_W = $clog2(ANA_SRC);

   // Register state
   logic [15:0] dig_probe, next_dig_probe;
   logic [17:0] ana_probe, next_ana_probe;
   logic [31:0] rdata, next_rdata;

   // Boot state
   dbgp_boot_type boot, next_boot;
   logic [1:0] settle, next_settle;
   logic dl_mode, next_dl_mode;
   logic strap_sync;

   // Command steering and download engine state
   dbgp_dl_type dl, next_dl;
   logic [31:0] hash, next_hash;
   logic [7:0] inst_major, next_inst_major;
   logic [7:0] inst_minor, next_inst_minor;
   logic [7:0] img_major, next_img_major;
   logic [7:0] img_minor, next_img_minor;
   logic img_ok, next_img_ok;
   logic rsp_valid, next_rsp_valid;
   dbgp_rsp_code_type rsp, next_rsp;
   logic norm_valid, next_norm_valid;
   dbgp_cmd_type norm_cmd, next_norm_cmd;

   // Pin state
   dbgp_pins_type pins, next_pins;
   logic aux_out_two_oe, next_aux_out_two_oe;
   logic [DAC_W-1:0] dac1, next_dac1, dac2, next_dac2;
   logic dac1_en, next_dac1_en, dac2_en, next_dac2_en;

   // Probe selection
   logic [DBGP_SIGS_PER_GROUP-1:0] group_sigs;
   logic group_hit;
   logic probe_bit;
   logic [DAC_W-1:0] ana_words [ANA_SRC];

   dbgp_sync2 u_strap_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .async_i(aux_out_two_in_i),
      .sync_o(strap_sync)
   );

   genvar gi;
   generate
      for (gi = 0; gi < ANA_SRC; gi++) begin : g_ana
         assign ana_words[gi] = ana_src_i[gi*DAC_W +: DAC_W];
      end
   endgenerate

   // Group code lookup; unknown codes route nothing
   always_comb begin
      group_hit = 1'b1;
      case (dig_probe[DBGP_GROUP_LSB +: 8]) // R3
         DBGP_GRP_CLOCK: group_sigs = probe_groups_i[0*DBGP_SIGS_PER_GROUP +: DBGP_SIGS_PER_GROUP];
         DBGP_GRP_TX_ENC: group_sigs = probe_groups_i[1*DBGP_SIGS_PER_GROUP +: DBGP_SIGS_PER_GROUP];
         DBGP_GRP_TIMER: group_sigs = probe_groups_i[2*DBGP_SIGS_PER_GROUP +: DBGP_SIGS_PER_GROUP];
         DBGP_GRP_CARD: group_sigs = probe_groups_i[3*DBGP_SIGS_PER_GROUP +: DBGP_SIGS_PER_GROUP];
         DBGP_GRP_TRANSCEIVE: begin
            group_sigs = probe_groups_i[4*DBGP_SIGS_PER_GROUP +: DBGP_SIGS_PER_GROUP];
         end
         DBGP_GRP_RX_DATA: group_sigs = probe_groups_i[5*DBGP_SIGS_PER_GROUP +: DBGP_SIGS_PER_GROUP];
         DBGP_GRP_RX_ERR: group_sigs = probe_groups_i[6*DBGP_SIGS_PER_GROUP +: DBGP_SIGS_PER_GROUP];
         default: begin
            group_sigs = '0;
            group_hit = 1'b0;
         end
      endcase
      // Signal codes above 8 are unused and show low
      if (group_hit && dig_probe[DBGP_POS_LSB +: 4] < 4'(DBGP_SIGS_PER_GROUP)) begin // R2
         probe_bit = group_sigs[dig_probe[DBGP_POS_LSB +: 4]];
      end else begin
         probe_bit = 1'b0;
      end
   end

   // Register port
   always_comb begin
      next_dig_probe = dig_probe;
      next_ana_probe = ana_probe;
      next_rdata = '0;
      if (reg_wr_i) begin
         case (reg_addr_i)
            DBGP_REG_DIG_PROBE: next_dig_probe = reg_wdata_i[15:0];
            DBGP_REG_ANA_PROBE: next_ana_probe = reg_wdata_i[17:0];
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            DBGP_REG_DIG_PROBE: next_rdata = {16'h0000, dig_probe};
            DBGP_REG_ANA_PROBE: next_rdata = {14'h0000, ana_probe};
            DBGP_REG_STATUS: begin
               next_rdata = {26'h0000000, img_ok, dl == DL_IMAGE, dl != DL_LOCKED,
                             boot == ST_RUN, aux_out_two_oe, dl_mode};
            end
            DBGP_REG_VERSION: next_rdata = {img_major, img_minor, inst_major, inst_minor};
            default: next_rdata = '0;
         endcase
      end
   end

   // Boot sequence and strap capture
   always_comb begin
      next_boot = boot;
      next_settle = settle;
      next_dl_mode = dl_mode;
      case (boot)
         ST_SETTLE: begin
            // Wait for the synchroniser to hold the strap level seen at release
            next_settle = settle + 2'h1;
            if (settle == DBGP_STRAP_SETTLE) begin
               next_dl_mode = strap_sync; // R7
               next_boot = ST_STARTUP;
            end
         end
         ST_STARTUP: begin
            if (boot_idle_irq_i) begin
               next_boot = ST_RUN; // R8
            end
         end
         ST_RUN: ; // Leaving download mode needs a reset with the strap low R10
         default: next_boot = ST_SETTLE;
      endcase
   end

   // Command steering and download engine
   always_comb begin
      next_dl = dl;
      next_hash = hash;
      next_inst_major = inst_major;
      next_inst_minor = inst_minor;
      next_img_major = img_major;
      next_img_minor = img_minor;
      next_img_ok = img_ok;
      next_rsp_valid = 1'b0;
      next_rsp = rsp;
      next_norm_valid = 1'b0;
      next_norm_cmd = norm_cmd;
      if (cmd_valid_i && boot != ST_SETTLE) begin
         if (!dl_mode) begin
            next_norm_valid = 1'b1; // R11
            next_norm_cmd = cmd_i;
         end else begin
            next_rsp_valid = 1'b1; // R11
            next_rsp = DBGP_RSP_OK;
            case (cmd_i.opcode)
               DBGP_OP_AUTH: begin
                  if (cmd_i.arg == AUTH_KEY) begin
                     next_dl = DL_OPEN; // R12
                  end else begin
                     next_dl = DL_LOCKED;
                     next_rsp = DBGP_RSP_AUTH_FAIL;
                  end
               end
               DBGP_OP_HEADER: begin
                  if (dl == DL_LOCKED) begin
                     next_rsp = DBGP_RSP_LOCKED; // R12
                  end else if (cmd_i.arg[15:8] < inst_major) begin
                     next_rsp = DBGP_RSP_OLD_MAJOR; // R13
                     next_dl = DL_OPEN;
                  end else begin
                     next_img_major = cmd_i.arg[15:8]; // R13
                     next_img_minor = cmd_i.arg[7:0];
                     next_hash = DBGP_HASH_SEED;
                     next_img_ok = 1'b0;
                     next_dl = DL_IMAGE;
                  end
               end
               DBGP_OP_DATA: begin
                  if (dl == DL_LOCKED) begin
                     next_rsp = DBGP_RSP_LOCKED; // R12
                  end else if (dl != DL_IMAGE) begin
                     next_rsp = DBGP_RSP_SEQUENCE;
                  end else begin
                     // Light mixing digest; a stronger core can replace this function
                     next_hash = ({hash[26:0], hash[31:27]} ^ cmd_i.arg) + DBGP_HASH_ADD; // R12
                  end
               end
               DBGP_OP_FINISH: begin
                  if (dl == DL_LOCKED) begin
                     next_rsp = DBGP_RSP_LOCKED;
                  end else if (dl != DL_IMAGE) begin
                     next_rsp = DBGP_RSP_SEQUENCE;
                  end else if (cmd_i.arg != hash) begin
                     next_rsp = DBGP_RSP_BAD_HASH; // R12
                     next_dl = DL_OPEN;
                  end else begin
                     next_img_ok = 1'b1;
                     next_inst_major = img_major; // R13
                     next_inst_minor = img_minor;
                     next_dl = DL_OPEN;
                  end
               end
               default: next_rsp = DBGP_RSP_SEQUENCE;
            endcase
         end
      end
   end

   // Pin drivers
   always_comb begin
      next_pins = pin_func_i;
      next_aux_out_two_oe = (boot == ST_RUN); // R6 R8
      // Reserved codes fall through with every pin normal
      case (dig_probe[DBGP_POS_LSB+4 +: 4]) // R1 R14
         DBGP_PIN_IRQ: next_pins.irq = probe_bit;
         DBGP_PIN_GENERAL_OUTPUT_ONE: next_pins.general_output_one = probe_bit;
         DBGP_PIN_AUX_OUT_TWO: next_pins.aux_out_two = probe_bit;
         DBGP_PIN_AUX_OUT_ONE: next_pins.aux_out_one = probe_bit;
         default: ;
      endcase
      if (boot != ST_RUN) begin
         next_pins.aux_out_two = 1'b0; // R6
      end
      // One converter per auxiliary pin, each with its own source select
      next_dac1_en = ana_probe[DBGP_ANA1_EN_BIT]; // R4
      next_dac2_en = ana_probe[DBGP_ANA2_EN_BIT] && boot == ST_RUN; // R4 R6
      next_dac1 = ana_words[ana_probe[DBGP_ANA1_LSB +: SEL_W]]; // R5
      next_dac2 = ana_words[ana_probe[DBGP_ANA2_LSB +: SEL_W]]; // R5
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         dig_probe <= DBGP_DIG_PROBE_RST;
         ana_probe <= DBGP_ANA_PROBE_RST;
         rdata <= '0;
         boot <= ST_SETTLE;
         settle <= '0;
         dl_mode <= 1'b0;
         dl <= DL_LOCKED;
         hash <= DBGP_HASH_SEED;
         inst_major <= INIT_MAJOR;
         inst_minor <= INIT_MINOR;
         img_major <= '0;
         img_minor <= '0;
         img_ok <= 1'b0;
         rsp_valid <= 1'b0;
         rsp <= DBGP_RSP_OK;
         norm_valid <= 1'b0;
         norm_cmd <= '0;
         pins <= '0;
         aux_out_two_oe <= 1'b0;
         dac1 <= '0;
         dac2 <= '0;
         dac1_en <= 1'b0;
         dac2_en <= 1'b0;
      end else begin
         dig_probe <= next_dig_probe;
         ana_probe <= next_ana_probe;
         rdata <= next_rdata;
         boot <= next_boot;
         settle <= next_settle;
         dl_mode <= next_dl_mode;
         dl <= next_dl;
         hash <= next_hash;
         inst_major <= next_inst_major;
         inst_minor <= next_inst_minor;
         img_major <= next_img_major;
         img_minor <= next_img_minor;
         img_ok <= next_img_ok;
         rsp_valid <= next_rsp_valid;
         rsp <= next_rsp;
         norm_valid <= next_norm_valid;
         norm_cmd <= next_norm_cmd;
         pins <= next_pins;
         aux_out_two_oe <= next_aux_out_two_oe;
         dac1 <= next_dac1;
         dac2 <= next_dac2;
         dac1_en <= next_dac1_en;
         dac2_en <= next_dac2_en;
      end
   end

   assign reg_rdata_o = rdata;
   assign pin_out_o = pins;
   assign aux_out_two_oe_o = aux_out_two_oe;
   assign aux_out_one_dac_o = dac1;
   assign aux_out_two_dac_o = dac2;
   assign aux_out_one_dac_en_o = dac1_en;
   assign aux_out_two_dac_en_o = dac2_en;
   assign normal_cmd_valid_o = norm_valid;
   assign normal_cmd_o = norm_cmd;
   assign dl_rsp_valid_o = rsp_valid;
   assign dl_rsp_o = rsp;
endmodule : dbgp_top

// File: verif/dbgp_assertions.sv
// Port-level checker for the debug probe top.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
module dbgp_assertions
   import dbgp_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic boot_idle_irq_i,
   input wire dbgp_pins_type pin_out_o,
   input wire logic aux_out_two_oe_o,
   input wire logic aux_out_two_dac_en_o,
   input wire logic cmd_valid_i,
   input wire dbgp_cmd_type cmd_i,
   input wire logic normal_cmd_valid_o,
   input wire dbgp_cmd_type normal_cmd_o,
   input wire logic dl_rsp_valid_o,
   input wire dbgp_rsp_code_type dl_rsp_o
);
   dbgp_op_type op_q;
   logic auth_q;
   logic irq_seen;
   // Lock state is rebuilt from answers, so no internal probe is needed
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         op_q <= DBGP_OP_AUTH;
         auth_q <= 1'b0;
         irq_seen <= 1'b0;
      end else begin
         op_q <= cmd_valid_i ? cmd_i.opcode : op_q;
         auth_q <= (dl_rsp_valid_o && op_q == DBGP_OP_AUTH) ? dl_rsp_o == DBGP_RSP_OK : auth_q;
         irq_seen <= irq_seen || boot_idle_irq_i;
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("read data without a read");
   a_pre_boot_quiet: assert property (
      !irq_seen |-> !aux_out_two_oe_o && !pin_out_o.aux_out_two && !aux_out_two_dac_en_o)
      else $error("aux_out_two pin used before boot");
   a_oe_after_boot: assert property (boot_idle_irq_i |-> ##[1:6] aux_out_two_oe_o)
      else $error("aux_out_two not turned to output");
   a_oe_holds: assert property (aux_out_two_oe_o |=> aux_out_two_oe_o)
      else $error("aux_out_two output dropped");
   a_cmd_forward: assert property (
      normal_cmd_valid_o |-> $past(cmd_valid_i) && normal_cmd_o == $past(cmd_i))
      else $error("normal command not forwarded");
   a_rsp_cause: assert property (
      dl_rsp_valid_o |-> $past(cmd_valid_i) && !normal_cmd_valid_o)
      else $error("download answer without command");
   a_lock_refuse: assert property (
      dl_rsp_valid_o && !auth_q && op_q != DBGP_OP_AUTH |-> dl_rsp_o == DBGP_RSP_LOCKED)
      else $error("command served while locked");
   a_auth_answer: assert property (
      dl_rsp_valid_o && op_q == DBGP_OP_AUTH |-> dl_rsp_o inside {DBGP_RSP_OK, DBGP_RSP_AUTH_FAIL})
      else $error("bad answer to authentication");
   c_dl_ok: cover property (dl_rsp_valid_o && dl_rsp_o == DBGP_RSP_OK);
   c_boot: cover property ($rose(aux_out_two_oe_o));
   c_fwd: cover property (normal_cmd_valid_o);
endmodule : dbgp_assertions

bind dbgp_top dbgp_assertions dbgp_assertions_i (.mclk_i, .rst_i, .reg_rd_i, .reg_rdata_o,
   .boot_idle_irq_i, .pin_out_o, .aux_out_two_oe_o, .aux_out_two_dac_en_o, .cmd_valid_i, .cmd_i,
   .normal_cmd_valid_o, .normal_cmd_o, .dl_rsp_valid_o, .dl_rsp_o);

// File: verif/dbgp_host.sv
// Host controller model: reset, strap level and command port.
// Assumes the caller waits for answers; gap sets how slowly it sends.
`timescale 1ns/1ps
module dbgp_host
   import dbgp_pkg::*;
(
   input wire logic mclk_i,
   output logic rst_o,
   output logic strap_o,
   output logic cmd_valid_o,
   output dbgp_cmd_type cmd_o
);
   initial begin
      rst_o = 1'b1;
      strap_o = 1'b0;
      cmd_valid_o = 1'b0;
      cmd_o = '0;
   end
   task automatic restart(input logic s);
      @(posedge mclk_i);
      strap_o <= s & strap_o;
      @(posedge mclk_i);
      rst_o <= 1'b1;
      @(posedge mclk_i);
      strap_o <= s;
      @(posedge mclk_i);
      rst_o <= 1'b0;
      // Strap held well past the settle window
      repeat (6) @(posedge mclk_i);
   endtask : restart
   task automatic send(input dbgp_op_type op, input logic [31:0] arg, input int gap);
      repeat (gap) @(posedge mclk_i);
      @(posedge mclk_i);
      cmd_valid_o <= 1'b1;
      cmd_o <= {op, arg};
      @(posedge mclk_i);
      cmd_valid_o <= 1'b0;
      // Idle bus shows no stale command
      cmd_o <= ~cmd_o;
   endtask : send
endmodule : dbgp_host

// File: verif/debug_probe_and_boot_strap_tb.sv
// Bench: host model, register tasks and a download model.
// Assumes the host model owns reset, strap and the command port.
`timescale 1ns/1ps
module debug_probe_and_boot_strap_tb;
   import dbgp_pkg::*;
   // Arbitrary key value
   localparam logic [31:0] KEY = 32'h3C3C0042;
   logic mclk, rst, strap, wr, rd, irq, cval, oe, en1, en2, nval, dval, pb, ok, auth_m, open_m;
   logic [7:0] addr, dac1, dac2;
   logic [7:0] codes [7] = '{DBGP_GRP_CLOCK, DBGP_GRP_TX_ENC, DBGP_GRP_TIMER, DBGP_GRP_CARD,
      DBGP_GRP_TRANSCEIVE, DBGP_GRP_RX_DATA, DBGP_GRP_RX_ERR};
   logic [15:0] seed = 16'h6071;
   logic [15:0] img_m, inst_m;
   logic [31:0] wdata, rdata, hash_m;
   logic [62:0] groups;
   logic [127:0] ana;
   dbgp_pins_type func, pins, expp;
   dbgp_cmd_type cmd, ncmd;
   dbgp_rsp_code_type rsp;
   int error_cnt = 0;
   int n_compared = 0;
   int g, s, p;
   wire logic pin2 = oe ? pins.aux_out_two : strap;
   dbgp_host dbgp_host_i (.mclk_i(mclk), .rst_o(rst), .strap_o(strap), .cmd_valid_o(cval),
      .cmd_o(cmd));
   dbgp_top #(.AUTH_KEY(KEY), .INIT_MAJOR(8'h01), .INIT_MINOR(8'h00)) dbgp_top_i (
      .mclk_i(mclk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .probe_groups_i(groups), .ana_src_i(ana),
      .pin_func_i(func), .boot_idle_irq_i(irq), .aux_out_two_in_i(pin2), .pin_out_o(pins),
      .aux_out_two_oe_o(oe), .aux_out_one_dac_o(dac1), .aux_out_two_dac_o(dac2), .aux_out_one_dac_en_o(en1),
      .aux_out_two_dac_en_o(en2), .cmd_valid_i(cval), .cmd_i(cmd), .normal_cmd_valid_o(nval),
      .normal_cmd_o(ncmd), .dl_rsp_valid_o(dval), .dl_rsp_o(rsp));
   function automatic void step();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
   endfunction : step
   task automatic check(input logic c, input string m);
      n_compared++;
      if (c !== 1'b1) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 check((rdata & mk) === (e & mk), "register read");
   endtask : rd_reg
   task automatic dl_cmd(input dbgp_op_type op, input logic [31:0] arg);
      dbgp_rsp_code_type e;
      e = DBGP_RSP_OK;
      if (!auth_m && op != DBGP_OP_AUTH) begin
         e = DBGP_RSP_LOCKED;
      end else if (op == DBGP_OP_AUTH) begin
         auth_m = (arg === KEY);
         // Any authentication closes an open image
         open_m = 1'b0;
         e = auth_m ? DBGP_RSP_OK : DBGP_RSP_AUTH_FAIL;
      end else if (op == DBGP_OP_HEADER) begin
         e = (arg[15:8] < inst_m[15:8]) ? DBGP_RSP_OLD_MAJOR : DBGP_RSP_OK;
         open_m = (e == DBGP_RSP_OK);
         hash_m = open_m ? DBGP_HASH_SEED : hash_m;
         img_m = open_m ? arg[15:0] : img_m;
      end else if (!open_m) begin
         e = DBGP_RSP_SEQUENCE;
      end else if (op == DBGP_OP_DATA) begin
         hash_m = ({hash_m[26:0], hash_m[31:27]} ^ arg) + DBGP_HASH_ADD;
      end else begin
         e = (hash_m === arg) ? DBGP_RSP_OK : DBGP_RSP_BAD_HASH;
         inst_m = (e == DBGP_RSP_OK) ? img_m : inst_m;
         open_m = 1'b0;
      end
      step();
      dbgp_host_i.send(op, arg, int'(seed[1:0]));
      #1 check(dval === 1'b1 && nval === 1'b0 && rsp === e, "download answer");
   endtask : dl_cmd
   task automatic image(input logic [31:0] hdr, input logic good);
      dl_cmd(DBGP_OP_HEADER, hdr);
      repeat (3) begin
         step();
         dl_cmd(DBGP_OP_DATA, {seed, ~seed});
      end
      dl_cmd(DBGP_OP_FINISH, good ? hash_m : ~hash_m);
   endtask : image
   task automatic finish_test();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      finish_test();
   end
   initial begin
      {wr, rd, irq, addr, wdata, groups, ana, func, auth_m, open_m, hash_m, img_m} = '0;
      inst_m = 16'h0100;
      dbgp_host_i.restart(1'b1);
      rd_reg(DBGP_REG_STATUS, 32'h1, 32'h1);
      dl_cmd(DBGP_OP_DATA, 32'h0);
      dl_cmd(DBGP_OP_AUTH, ~KEY);
      dl_cmd(DBGP_OP_HEADER, 32'h0100);
      dl_cmd(DBGP_OP_AUTH, KEY);
      dl_cmd(DBGP_OP_FINISH, 32'h0);
      image(32'h0102, 1'b0);
      image(32'h0203, 1'b1);
      wr_reg(DBGP_REG_VERSION, 32'h0);
      rd_reg(DBGP_REG_VERSION, 32'hFFFF, 32'h0203);
      rd_reg(DBGP_REG_STATUS, 32'h3F, 32'h29);
      dl_cmd(DBGP_OP_HEADER, 32'h0105);
      dl_cmd(DBGP_OP_DATA, 32'h0);
      dbgp_host_i.restart(1'b0);
      rd_reg(DBGP_REG_STATUS, 32'h7, 32'h0);
      rd_reg(DBGP_REG_DIG_PROBE, 32'hFFFF, 32'hF000);
      rd_reg(8'h10, 32'hFFFFFFFF, 32'h0);
      for (g = 0; g < 4; g++) begin
         step();
         dbgp_host_i.send(dbgp_op_type'(g), {seed, ~seed}, g);
         #1 check(nval === 1'b1 && dval === 1'b0 && ncmd === {2'(g), seed, ~seed}, "normal");
      end
      @(posedge mclk);
      groups <= '1;
      func <= '1;
      wr_reg(DBGP_REG_DIG_PROBE, 32'h2801);
      wr_reg(DBGP_REG_ANA_PROBE, 32'h00030000);
      repeat (3) @(posedge mclk);
      #1 check(pins.aux_out_two === 1'b0 && oe === 1'b0 && en2 === 1'b0 && en1 === 1'b1,
         "aux_out_two before boot");
      @(posedge mclk);
      irq <= 1'b1;
      repeat (8) @(posedge mclk);
      #1 check(oe === 1'b1, "aux_out_two after boot");
      rd_reg(DBGP_REG_STATUS, 32'h7, 32'h6);
      for (p = 0; p < 16; p++) begin
         @(posedge mclk);
         step();
         groups <= {seed[14:0], seed, ~seed, seed ^ 16'h5A5A};
         func <= seed[3:0];
         g = p % 7;
         s = int'(seed[11:4]) % 9;
         wr_reg(DBGP_REG_DIG_PROBE, {16'h0, 4'(p), 4'(s), codes[g]});
         repeat (3) @(posedge mclk);
         #1 expp = func;
         pb = groups[9 * g + s];
         case (p)
            0: expp.irq = pb;
            1: expp.general_output_one = pb;
            2: expp.aux_out_two = pb;
            3: expp.aux_out_one = pb;
            default: ;
         endcase
         check(pins === expp, "probe routing");
      end
      for (p = 0; p < 4; p++) begin
         @(posedge mclk);
         for (g = 0; g < 8; g++) begin
            step();
            ana[16 * g +: 16] <= seed;
         end
         wr_reg(DBGP_REG_ANA_PROBE, {14'h0, 2'(p), 4'h0, seed[7:4], 4'h0, seed[3:0]});
         repeat (3) @(posedge mclk);
         #1 ok = (!p[0] || dac1 === ana[8 * seed[3:0] +: 8]) && en1 === p[0];
         ok = ok && (!p[1] || dac2 === ana[8 * seed[7:4] +: 8]) && en2 === p[1];
         check(ok, "analog probe");
      end
      finish_test();
   end
endmodule : debug_probe_and_boot_strap_tb
